/* logic/dma_lane_pkg.sv */
// shared constants and types for the dma lane, error and status block
package dma_lane_pkg;
    localparam int NUM_CHAN = 8;
    localparam logic [31:0] REG_BASE = 32'hA000_0000;
    localparam logic [31:0] BLOCK_MASK = 32'hFFFF_FF00;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLEAR = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_REQSEL = 8'h0C;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [7:0] REQSEL_RESET = 8'h00;
    localparam int BIT_ANY = 0;
    localparam int BIT_DONE = 1;
    localparam int BIT_HALF = 2;
    localparam int BIT_ERR = 3;
    localparam int CFG_EN = 0;
    localparam int CFG_DONE_IE = 1;
    localparam int CFG_HALF_IE = 2;
    localparam int CFG_ERR_IE = 3;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_ERROR = 2'h1;

    // one pending write from the transfer engine
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] size;
        logic [31:0] data;
        logic [2:0] chan;
    } wr_item_s;

    // per-channel engine events, one cycle each
    typedef struct packed {
        logic done;
        logic half;
        logic err;
    } chan_evt_s;
endpackage

/* logic/dma_lane_fifo.sv */
// parameterised valid/ready fifo held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module dma_lane_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    wire logic doPush;
    wire logic doPop;
    assign inReady = int'(count_ff) < DEPTH;
    assign outValid = count_ff != '0;
    assign outData = mem_ff[rdPtr_ff];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= doPush ? AW'(int'(wrPtr_ff) + 1) : wrPtr_ff;
            rdPtr_ff <= doPop ? AW'(int'(rdPtr_ff) + 1) : rdPtr_ff;
            count_ff <= (AW+1)'(int'(count_ff) + int'(doPush) - int'(doPop));
        end
    end
endmodule
`default_nettype wire

/* logic/dma_lane_error_irq_status.sv */
// dma write-lane replication, error handling, request select and status registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - register accesses must be 32-bit, else fault
// - byte and halfword writes replicated on lanes
// - reserved region access flags transfer error
// - transfer error clears channel enable bit
// - error sets flag, irq only if enabled
// - half, done, error each with enable
// - per-channel select between peripheral and adc
// - register block decoded at base 0xA0000000
// - status register offset 0x00, read-only, zero
// - clear register offset 0x04, write-only, zero
// - any-event flag at status bit 4n
// - done flag at status bit 4n+1
// - half flag at status bit 4n+2
// - error flag at status bit 4n+3
// - flags reset zero, software clears writing one
module dma_lane_error_irq_status (
    input wire logic clk,
    input wire logic srst,
    // register slave side (ahb)
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic hardFault,
    // engine side
    input wire dma_lane_pkg::chan_evt_s [dma_lane_pkg::NUM_CHAN-1:0] chanEvt,
    input wire logic wrReqValid,
    output logic wrReqReady,
    input wire dma_lane_pkg::wr_item_s wrReq,
    input wire logic rdErr,
    input wire logic [2:0] rdErrChan,
    // master write side (ahb)
    output logic [31:0] mHaddr,
    output logic [1:0] mHtrans,
    output logic mHwrite,
    output logic [2:0] mHsize,
    output logic [31:0] mHwdata,
    input wire logic mHready,
    input wire logic [1:0] mHresp,
    // request mapping and interrupts
    input wire logic [dma_lane_pkg::NUM_CHAN-1:0] periphReq,
    input wire logic adcReq,
    output logic [dma_lane_pkg::NUM_CHAN-1:0] chanReq,
    output logic [dma_lane_pkg::NUM_CHAN-1:0] chanEnable,
    output logic [dma_lane_pkg::NUM_CHAN-1:0] chanIrq
);
    localparam int N = dma_lane_pkg::NUM_CHAN;

    typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_DATA} wr_state_e;

    // slave address phase capture
    logic apValid_ff;
    logic apWrite_ff;
    logic [7:0] apOfs_ff;
    logic [31:0] status_ff;
    logic [31:0] config_ff;
    logic [7:0] reqSel_ff;
    logic errPend_ff;
    logic hardFault_ff;
    logic [31:0] hrdata_ff;

    wire logic busTake = hsel && hready && htrans[1];
    wire logic inBlock = (haddr & dma_lane_pkg::BLOCK_MASK) == dma_lane_pkg::REG_BASE;
    wire logic badSize = hsize != dma_lane_pkg::SIZE_WORD;
    wire logic goodTake = busTake && inBlock && !badSize;
    wire logic badTake = busTake && (badSize || !inBlock);
    wire logic clrWrite = apValid_ff && apWrite_ff && apOfs_ff == dma_lane_pkg::OFS_CLEAR;
    wire logic cfgWrite = apValid_ff && apWrite_ff && apOfs_ff == dma_lane_pkg::OFS_CONFIG;
    wire logic selWrite = apValid_ff && apWrite_ff && apOfs_ff == dma_lane_pkg::OFS_REQSEL;
    wire logic [31:0] clrMask = clrWrite ? hwdata : 32'h0000_0000;

    // register read mux; clear register reads zero
    wire logic [31:0] rdMux =
        (haddr[7:0] == dma_lane_pkg::OFS_STATUS) ? status_ff :
        (haddr[7:0] == dma_lane_pkg::OFS_CONFIG) ? config_ff :
        (haddr[7:0] == dma_lane_pkg::OFS_REQSEL) ? {24'h000000, reqSel_ff} :
        32'h0000_0000;

    // write path: fifo then one-deep master pipeline
    wr_state_e wrState_ff;
    dma_lane_pkg::wr_item_s cur_ff;
    dma_lane_pkg::wr_item_s fifoOut;
    logic fifoValid;
    wire logic fifoTake = fifoValid && wrState_ff == WR_IDLE;
    wire logic wrErr = wrState_ff == WR_DATA && mHready && mHresp == dma_lane_pkg::RESP_ERROR;

    dma_lane_fifo #(
        .WIDTH($bits(dma_lane_pkg::wr_item_s)),
        .DEPTH(dma_lane_pkg::FIFO_DEPTH)
    ) wrFifo (
        .clk(clk),
        .srst(srst),
        .inValid(wrReqValid),
        .inReady(wrReqReady),
        .inData(wrReq),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoOut)
    );

    // lane replication for narrow writes
    wire logic [31:0] laneData =
        (cur_ff.size == dma_lane_pkg::SIZE_BYTE) ? {4{cur_ff.data[7:0]}} :
        (cur_ff.size == dma_lane_pkg::SIZE_HALF) ? {2{cur_ff.data[15:0]}} :
        cur_ff.data;

    always_ff @(posedge clk) begin
        if (srst) begin
            wrState_ff <= WR_IDLE;
            cur_ff <= '0;
            mHwdata <= 32'h0000_0000;
        end else begin
            case (wrState_ff)
                WR_IDLE: begin
                    if (fifoValid) begin
                        cur_ff <= fifoOut;
                        wrState_ff <= WR_ADDR;
                    end
                end
                WR_ADDR: begin
                    if (mHready) begin
                        mHwdata <= laneData;
                        wrState_ff <= WR_DATA;
                    end
                end
                WR_DATA: begin
                    if (mHready) begin
                        wrState_ff <= WR_IDLE;
                    end
                end
                default: wrState_ff <= WR_IDLE;
            endcase
        end
    end

    assign mHaddr = cur_ff.addr;
    assign mHsize = cur_ff.size;
    assign mHwrite = wrState_ff == WR_ADDR;
    assign mHtrans = (wrState_ff == WR_ADDR) ? dma_lane_pkg::TRANS_NONSEQ : 2'h0;

    // reserved region errors from read and write phases, per channel
    wire logic [N-1:0] errHit;
    wire logic [N-1:0] doneHit;
    wire logic [N-1:0] halfHit;
    logic [31:0] nxt_status;
    logic [31:0] nxt_config;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : chanGen
            assign errHit[g] = chanEvt[g].err
                || (rdErr && rdErrChan == 3'(g))
                || (wrErr && cur_ff.chan == 3'(g));
            assign doneHit[g] = chanEvt[g].done;
            assign halfHit[g] = chanEvt[g].half;
            // set beats clear; zero bits of the clear word leave flags alone
            assign nxt_status[4*g+dma_lane_pkg::BIT_ANY] = (errHit[g] || doneHit[g] || halfHit[g])
                || (status_ff[4*g+dma_lane_pkg::BIT_ANY] && !clrMask[4*g+dma_lane_pkg::BIT_ANY]);
            assign nxt_status[4*g+dma_lane_pkg::BIT_DONE] = doneHit[g]
                || (status_ff[4*g+dma_lane_pkg::BIT_DONE] && !clrMask[4*g+dma_lane_pkg::BIT_DONE]);
            assign nxt_status[4*g+dma_lane_pkg::BIT_HALF] = halfHit[g]
                || (status_ff[4*g+dma_lane_pkg::BIT_HALF] && !clrMask[4*g+dma_lane_pkg::BIT_HALF]);
            assign nxt_status[4*g+dma_lane_pkg::BIT_ERR] = errHit[g]
                || (status_ff[4*g+dma_lane_pkg::BIT_ERR] && !clrMask[4*g+dma_lane_pkg::BIT_ERR]);
            // software writes the config nibble; an error clears enable
            assign nxt_config[4*g+3:4*g] = errHit[g]
                ? ((cfgWrite ? hwdata[4*g+3:4*g] : config_ff[4*g+3:4*g]) & 4'hE)
                : (cfgWrite ? hwdata[4*g+3:4*g] : config_ff[4*g+3:4*g]);
            assign chanEnable[g] = config_ff[4*g+dma_lane_pkg::CFG_EN];
            assign chanReq[g] = reqSel_ff[g] ? adcReq : periphReq[g];
            assign chanIrq[g] =
                (status_ff[4*g+dma_lane_pkg::BIT_DONE] && config_ff[4*g+dma_lane_pkg::CFG_DONE_IE])
                || (status_ff[4*g+dma_lane_pkg::BIT_HALF] && config_ff[4*g+dma_lane_pkg::CFG_HALF_IE])
                || (status_ff[4*g+dma_lane_pkg::BIT_ERR] && config_ff[4*g+dma_lane_pkg::CFG_ERR_IE]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            status_ff <= dma_lane_pkg::STATUS_RESET;
            config_ff <= dma_lane_pkg::CONFIG_RESET;
            reqSel_ff <= dma_lane_pkg::REQSEL_RESET;
        end else begin
            status_ff <= nxt_status;
            config_ff <= nxt_config;
            reqSel_ff <= selWrite ? hwdata[7:0] : reqSel_ff;
        end
    end

    // slave pipeline: two-cycle error response for bad size or address
    always_ff @(posedge clk) begin
        if (srst) begin
            apValid_ff <= 1'b0;
            apWrite_ff <= 1'b0;
            apOfs_ff <= 8'h00;
            errPend_ff <= 1'b0;
            hardFault_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            apValid_ff <= goodTake;
            apWrite_ff <= hwrite;
            apOfs_ff <= haddr[7:0];
            errPend_ff <= badTake;
            hardFault_ff <= busTake && inBlock && badSize;
            hrdata_ff <= (goodTake && !hwrite) ? rdMux : 32'h0000_0000;
        end
    end

    logic errSecond_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            errSecond_ff <= 1'b0;
        end else begin
            errSecond_ff <= errPend_ff;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = !errPend_ff;
    assign hresp = (errPend_ff || errSecond_ff) ? dma_lane_pkg::RESP_ERROR
                                                : dma_lane_pkg::RESP_OKAY;
    assign hardFault = hardFault_ff;

    // checks
    sequence narrowTake;
        busTake && inBlock && badSize;
    endsequence
    sequence errResp;
        hresp == dma_lane_pkg::RESP_ERROR && !hreadyout ##1 hresp == dma_lane_pkg::RESP_ERROR && hreadyout;
    endsequence
    narrow_fault_a: assert property (@(posedge clk) disable iff (srst)
        narrowTake |=> hardFault and errResp) else $error("narrow register access not faulted");
    lane_repl_a: assert property (@(posedge clk) disable iff (srst)
        wrState_ff == WR_DATA && mHsize == dma_lane_pkg::SIZE_BYTE |->
        mHwdata[31:24] == mHwdata[7:0] && mHwdata[15:8] == mHwdata[7:0])
        else $error("byte write not replicated");
    half_repl_a: assert property (@(posedge clk) disable iff (srst)
        wrState_ff == WR_DATA && mHsize == dma_lane_pkg::SIZE_HALF |->
        mHwdata[31:16] == mHwdata[15:0]) else $error("halfword write not replicated");
    err_disable_a: assert property (@(posedge clk) disable iff (srst)
        errHit[1] |=> !chanEnable[1] && status_ff[7]) else $error("error did not disable channel");
    done_set_a: assert property (@(posedge clk) disable iff (srst)
        doneHit[0] |=> status_ff[1] && status_ff[0]) else $error("done flag not set");
    half_set_a: assert property (@(posedge clk) disable iff (srst)
        halfHit[5] |=> status_ff[22] && status_ff[20]) else $error("half flag not set");
    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        clrMask[1] && doneHit[0] |=> status_ff[1]) else $error("clear beat hardware set");
    clear_flag_a: assert property (@(posedge clk) disable iff (srst)
        clrMask[7] && !errHit[1] |=> !status_ff[7]) else $error("flag not cleared");
    irq_gate_a: assert property (@(posedge clk) disable iff (srst)
        chanIrq[0] |-> (status_ff[3] && config_ff[3]) || (status_ff[1] && config_ff[1])
        || (status_ff[2] && config_ff[2])) else $error("irq without enabled flag");
    req_sel_a: assert property (@(posedge clk) disable iff (srst)
        reqSel_ff[0] |-> chanReq[0] == adcReq) else $error("adc select ignored");
endmodule
`default_nettype wire

/* verif/ahb_wr_slave.sv */
// behavioural ahb write slave that ignores hsize, with wait states and a reserved region
`timescale 1ns/1ps
`default_nettype none
module ahb_wr_slave (
    input wire logic clk,
    input wire logic srst,
    input wire logic stall,
    input wire logic [31:0] mHaddr,
    input wire logic [1:0] mHtrans,
    input wire logic mHwrite,
    input wire logic [31:0] mHwdata,
    output logic mHready,
    output logic [1:0] mHresp,
    output logic [31:0] lastAddr,
    output logic [31:0] lastData,
    output logic [7:0] nWr
);
    logic ph_ff, err_ff, sec_ff;
    logic [31:0] adr_ff;
    // error answer takes two cycles: ready low first, then high
    assign mHready = !ph_ff || (!stall && (!err_ff || sec_ff));
    assign mHresp = (ph_ff && err_ff) ? dma_lane_pkg::RESP_ERROR : dma_lane_pkg::RESP_OKAY;
    always_ff @(posedge clk) begin
        if (srst) begin
            ph_ff <= 1'b0;
            err_ff <= 1'b0;
            sec_ff <= 1'b0;
            adr_ff <= 32'h0;
            lastAddr <= 32'h0;
            lastData <= 32'h0;
            nWr <= 8'h00;
        end else if (mHready) begin
            // only write transfers open a data phase here
            ph_ff <= mHtrans[1] && mHwrite;
            err_ff <= mHaddr[31:28] == 4'hF;
            adr_ff <= {mHaddr[31:2], 2'h0};
            sec_ff <= 1'b0;
            if (ph_ff && !err_ff) begin
                lastAddr <= adr_ff;
                lastData <= mHwdata;
                nWr <= nWr + 8'h01;
            end
        end else if (ph_ff && err_ff && !stall) begin
            sec_ff <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verif/tb_dma_lane_error_irq_status.sv */
// self-checking bench for lane replication, error handling and status registers
`timescale 1ns/1ps
`default_nettype none
module tb_dma_lane_error_irq_status;
    localparam logic [31:0] B = dma_lane_pkg::REG_BASE;
    localparam logic [2:0] SZ_B = dma_lane_pkg::SIZE_BYTE;
    localparam logic [2:0] SZ_H = dma_lane_pkg::SIZE_HALF;
    localparam logic [2:0] SZ_W = dma_lane_pkg::SIZE_WORD;
    logic clk, srst, hsel, hwrite, hready, hreadyout, hardFault, hf;
    logic [31:0] haddr, hwdata, hrdata, mHaddr, mHwdata, lastAddr, lastData, rd;
    logic [1:0] htrans, hresp, mHtrans, mHresp, rs;
    logic [2:0] hsize, rdErrChan, mHsize;
    logic wrReqValid, wrReqReady, rdErr, mHready, adcReq, stall, mHwrite;
    logic [7:0] periphReq, chanReq, chanEnable, chanIrq, nWr;
    dma_lane_pkg::chan_evt_s [7:0] chanEvt;
    dma_lane_pkg::wr_item_s wrReq;
    int n_errors = 0;
    int compares = 0;
    assign hready = hreadyout;
    dma_lane_error_irq_status i_dma_lane_error_irq_status (.clk, .srst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .hardFault, .chanEvt,
        .wrReqValid, .wrReqReady, .wrReq, .rdErr, .rdErrChan, .mHaddr, .mHtrans, .mHwrite,
        .mHsize, .mHwdata, .mHready, .mHresp, .periphReq, .adcReq, .chanReq, .chanEnable,
        .chanIrq);
    ahb_wr_slave i_ahb_wr_slave (.clk, .srst, .stall, .mHaddr, .mHtrans, .mHwrite, .mHwdata,
        .mHready, .mHresp, .lastAddr, .lastData, .nWr);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task summarize;
        $display("checks %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask
    // address phase, then data phase until hreadyout, sampled before the closing edge
    task bus(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
        int k;
        @(negedge clk);
        hsel = 1'b1;
        haddr = a;
        htrans = dma_lane_pkg::TRANS_NONSEQ;
        hwrite = w;
        hsize = sz;
        @(negedge clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = d;
        hf = hardFault;
        for (k = 0; k < 8 && hreadyout !== 1'b1; k++) @(negedge clk);
        rd = hrdata;
        rs = hresp;
        // return off the edge so that callers see registers after the data phase closes
        @(negedge clk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, SZ_W, d);
    endtask
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, SZ_W, 32'h0);
        chk(nm, e, rd);
    endtask
    task push(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d, input int c);
        int k;
        @(negedge clk);
        wrReqValid = 1'b1;
        wrReq = '{addr: a, size: sz, data: d, chan: c[2:0]};
        for (k = 0; k < 50 && wrReqReady !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        wrReqValid = 1'b0;
    endtask
    task xfer(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d,
              input logic [31:0] ea, input logic [31:0] ed);
        logic [7:0] n0;
        int k;
        n0 = nWr;
        push(a, sz, d, 1);
        for (k = 0; k < 50 && nWr == n0; k++) @(negedge clk);
        chk("wr addr", ea, lastAddr);
        chk("wr data", ed, lastData);
        chk("wr size", sz, mHsize);
    endtask
    task evt(input int c, input logic [2:0] p);
        @(negedge clk);
        chanEvt[c] = p;
        @(negedge clk);
        chanEvt = '0;
    endtask
    task t_reset;
        rdc("status", B, dma_lane_pkg::STATUS_RESET);
        rdc("clear", B + 32'h4, 32'h0);
        wr(B, 32'hFFFF_FFFF);
        rdc("status ro", B, 32'h0);
        chk("enable", 32'h0, chanEnable);
    endtask
    task t_lanes;
        wr(B + 32'h8, 32'h0000_0011);
        xfer(32'h2000_0003, SZ_B, 32'hAB, 32'h2000_0000, 32'hABAB_ABAB);
        xfer(32'h2000_0006, SZ_H, 32'hABCD, 32'h2000_0004, 32'hABCD_ABCD);
        xfer(32'h2000_0008, SZ_W, 32'h1234_5678, 32'h2000_0008, 32'h1234_5678);
    endtask
    task t_err;
        int k;
        wr(B + 32'h8, 32'h0000_0190);
        push(32'hF000_0000, SZ_W, 32'h55, 1);
        for (k = 0; k < 40 && chanEnable[1] !== 1'b0; k++) @(negedge clk);
        chk("enable wr err", 32'h04, chanEnable);
        chk("irq wr err", 32'h02, chanIrq);
        @(negedge clk);
        rdErr = 1'b1;
        rdErrChan = 3'h2;
        @(negedge clk);
        rdErr = 1'b0;
        chk("enable rd err", 32'h00, chanEnable);
        chk("irq masked", 32'h02, chanIrq);
        rdc("status err", B, 32'h0000_0990);
        wr(B + 32'h4, 32'hFFFF_FFFF);
        chk("irq cleared", 32'h00, chanIrq);
    endtask
    task t_events;
        logic [31:0] v;
        int e;
        for (e = 0; e < 3; e++) begin
            wr(B + 32'h8, 32'h1 << (dma_lane_pkg::CFG_DONE_IE + e));
            evt(0, 3'h4 >> e);
            evt(5, 3'h4 >> e);
            chk("irq event", 32'h01, chanIrq);
            v = 32'h1 | (32'h2 << e);
            rdc("status event", B, v | (v << 20));
            wr(B + 32'h4, 32'hFFFF_FFFF);
            chk("irq clear", 32'h00, chanIrq);
        end
    endtask
    task t_clear;
        evt(0, 3'h6);
        bus(1'b1, B + 32'h4, SZ_B, 32'hFFFF_FFFF);
        chk("fault", 32'h1, hf);
        chk("fault resp", dma_lane_pkg::RESP_ERROR, rs);
        wr(B + 32'h4, 32'h0000_0002);
        rdc("partial clear", B, 32'h5);
        // done is raised in the very cycle that its clear lands
        fork
            wr(B + 32'h4, 32'h0000_0002);
            begin
                repeat (2) @(negedge clk);
                chanEvt[0] = 3'h4;
                @(negedge clk);
                chanEvt = '0;
            end
        join
        rdc("set wins", B, 32'h7);
        bus(1'b0, B + 32'h100, SZ_W, 32'h0);
        chk("outside resp", dma_lane_pkg::RESP_ERROR, rs);
        chk("outside fault", 32'h0, hf);
        wr(B + 32'h4, 32'hFFFF_FFFF);
    endtask
    task t_sel;
        wr(B + 32'hC, 32'h0F);
        @(negedge clk);
        periphReq = 8'h5A;
        adcReq = 1'b1;
        #1 chk("req adc hi", 32'h5F, chanReq);
        periphReq = 8'hA5;
        adcReq = 1'b0;
        #1 chk("req adc lo", 32'hA0, chanReq);
    endtask
    task t_fifo;
        logic [7:0] n0;
        int n;
        int k;
        wr(B + 32'h8, 32'h0000_1000);
        n0 = nWr;
        n = 0;
        @(negedge clk);
        stall = 1'b1;
        for (k = 0; k < 24; k++) begin
            wrReq = '{addr: 32'h3000_0000, size: SZ_W, data: k, chan: 3'h3};
            wrReqValid = 1'b1;
            if (wrReqReady !== 1'b1) break;
            n++;
            @(negedge clk);
        end
        // a full fifo plus the one word held by the stalled master stage
        chk("fifo refuses", dma_lane_pkg::FIFO_DEPTH + 1, n);
        stall = 1'b0;
        for (k = 0; k < 100 && wrReqReady !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        wrReqValid = 1'b0;
        for (k = 0; k < 300 && nWr != n0 + n + 1; k++) @(negedge clk);
        chk("drained", n0 + n + 1, nWr);
        chk("last data", n, lastData);
    endtask
    initial begin
        srst = 1'b1;
        {hsel, hwrite, rdErr, wrReqValid, adcReq, stall, hf} = '0;
        {haddr, hwdata, rd} = '0;
        {htrans, rs, hsize, rdErrChan, periphReq} = '0;
        chanEvt = '0;
        wrReq = '0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_lanes();
        t_err();
        t_events();
        t_clear();
        t_sel();
        t_fifo();
        summarize();
    end
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
